// ===== rtl/ddrct_defines.svh
`ifndef DDRCT_DEFINES_SVH
`define DDRCT_DEFINES_SVH

// ==========================================================================
// Register map (byte addresses on the plain register port)
`define DDRCT_REG_CTRL 4'h0
`define DDRCT_REG_STATUS 4'h4
`define DDRCT_REG_MODE 4'h8
`define DDRCT_REG_WCOUNT 4'hc

// ==========================================================================
// Control register fields and reset values
`define DDRCT_CTRL_EN 0
`define DDRCT_CTRL_CLR 1
`define DDRCT_CTRL_EN_RST 1'b1

// ==========================================================================
// Status register field positions
`define DDRCT_ST_BANK_LSB 0
`define DDRCT_ST_BANK_MSB 3
`define DDRCT_ST_PD_PRE 4
`define DDRCT_ST_PD_ACT 5
`define DDRCT_ST_SELF 6
`define DDRCT_ST_RFC 7
`define DDRCT_ST_WR 8
`define DDRCT_ST_RD 9
`define DDRCT_ST_DLL_ON 10

// ==========================================================================
// Address pin fields
`define DDRCT_AP_BIT 10
`define DDRCT_MODE_MSB 6
`define DDRCT_BL_MSB 2
`define DDRCT_BL_LSB 0
`define DDRCT_CL_MSB 6
`define DDRCT_CL_LSB 4
`define DDRCT_DLL_OFF_BIT 0
`define DDRCT_BA_MODE 2'h0
`define DDRCT_BA_EXT 2'h1

// ==========================================================================
// Mode encodings, lengths and latencies in half link cycles
`define DDRCT_MODE_RST 7'h22
`define DDRCT_BL4 3'h2
`define DDRCT_BL8 3'h3
`define DDRCT_LEN2 4'h2
`define DDRCT_LEN4 4'h4
`define DDRCT_LEN8 4'h8
`define DDRCT_CL25 3'h6
`define DDRCT_CL3 3'h3
`define DDRCT_HT2 4'h4
`define DDRCT_HT25 4'h5
`define DDRCT_HT3 4'h6
`define DDRCT_WAIT_DATA 4'h1
`define DDRCT_WAIT_PRE 4'h2

// ==========================================================================
// Refresh cycle time counted in link clock cycles
`define DDRCT_RFC_CYC 4'h3

// ==========================================================================
// Command pin patterns {cs_n, ras_n, cas_n, we_n}
`define DDRCT_PAT_NOP 4'h7
`define DDRCT_PAT_ACT 4'h3
`define DDRCT_PAT_READ 4'h5
`define DDRCT_PAT_WRITE 4'h4
`define DDRCT_PAT_BST 4'h6
`define DDRCT_PAT_PRE 4'h2
`define DDRCT_PAT_REF 4'h1
`define DDRCT_PAT_MRS 4'h0

`endif

// ===== rtl/ddrct_pkg.sv
package ddrct_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_BST, CMD_PRE, CMD_REF,
    CMD_MRS
  } ddrct_cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF
  } ddrct_pwr_t;
endpackage : ddrct_pkg

// ===== rtl/ddrct_link_if.sv
`timescale 1ns/1ps
interface ddrct_link_if;
  import ddrct_pkg::*;
  logic rise;
  logic fall;
  logic cke;
  logic cke_prev;
  ddrct_cmd_t cmd;
  logic [12:0] addr;
  logic [1:0] ba;
  logic dqs_edge;
  logic [15:0] dq;
  logic [1:0] dm;

  modport front (output rise, fall, cke, cke_prev, cmd, addr, ba, dqs_edge,
    dq, dm);
  modport core (input rise, fall, cke, cke_prev, cmd, addr, ba, dqs_edge,
    dq, dm);
endinterface : ddrct_link_if

// ===== rtl/ddrct_front.sv
`timescale 1ns/1ps
`include "ddrct_defines.svh"
module ddrct_front import ddrct_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Link pins
  input wire logic mem_clk,
  input wire logic mem_cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic [1:0] ba,
  input wire logic [15:0] dq_i,
  input wire logic dqs_i,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  // Decoded link toward the core
  ddrct_link_if.front lnk
);
  // ========================================================================
  // Two-flop synchronisers; every pin crosses with the same delay so the
  // command, address and data groups stay aligned with their clock edges.
  logic [39:0] raw;
  logic [39:0] s1_q;
  logic [39:0] s2_q;
  logic clk_prev_q;
  logic dqs_prev_q;
  logic cke_prev_q;
  logic s_clk, s_cke, s_dqs;
  logic [3:0] s_cmd;
  logic [12:0] s_addr;
  logic [1:0] s_ba, s_dm;
  logic [15:0] s_dq;

  assign raw = {mem_clk, mem_cke, cs_n, ras_n, cas_n, we_n, addr, ba, dq_i,
    dqs_i, upper_byte_mask, lower_byte_mask};
  assign {s_clk, s_cke, s_cmd, s_addr, s_ba, s_dq, s_dqs, s_dm} = s2_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      clk_prev_q <= 1'b0;
      dqs_prev_q <= 1'b0;
      cke_prev_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= raw;
      s2_q <= s1_q;
      clk_prev_q <= s_clk;
      dqs_prev_q <= s_dqs;
      if (s_clk && !clk_prev_q) begin
        cke_prev_q <= s_cke;
      end
    end
  end

  // ========================================================================
  // Edges and command decode
  assign lnk.rise = clk_en && s_clk && !clk_prev_q;
  assign lnk.fall = clk_en && !s_clk && clk_prev_q;
  assign lnk.dqs_edge = clk_en && (s_dqs != dqs_prev_q);
  assign lnk.cke = s_cke;
  assign lnk.cke_prev = cke_prev_q;
  assign lnk.addr = s_addr;
  assign lnk.ba = s_ba;
  assign lnk.dq = s_dq;
  assign lnk.dm = s_dm;

  always_comb begin
    case (s_cmd)
      `DDRCT_PAT_ACT: lnk.cmd = CMD_ACT;
      `DDRCT_PAT_READ: lnk.cmd = CMD_READ;
      `DDRCT_PAT_WRITE: lnk.cmd = CMD_WRITE;
      `DDRCT_PAT_BST: lnk.cmd = CMD_BST;
      `DDRCT_PAT_PRE: lnk.cmd = CMD_PRE;
      `DDRCT_PAT_REF: lnk.cmd = CMD_REF;
      `DDRCT_PAT_MRS: lnk.cmd = CMD_MRS;
      default: lnk.cmd = CMD_NOP;
    endcase
  end
endmodule : ddrct_front

// ===== rtl/ddrct_core.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ddrct_defines.svh"
module ddrct_core import ddrct_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Link pins
  input wire logic mem_clk,
  input wire logic mem_cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic [1:0] ba,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  ddrct_link_if lnk ();

  ddrct_front u_front (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .mem_clk(mem_clk),
    .mem_cke(mem_cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .addr(addr),
    .ba(ba),
    .dq_i(dq_i),
    .dqs_i(dqs_i),
    .upper_byte_mask(upper_byte_mask),
    .lower_byte_mask(lower_byte_mask),
    .lnk(lnk)
  );

  // ========================================================================
  // State
  logic ctrl_en_q;
  logic [6:0] mode_q;
  logic dll_off_q;
  logic [3:0] bank_q;
  ddrct_pwr_t pwr_q;
  logic [3:0] rfc_q;
  logic [31:0] wcount_q;
  logic [7:0] mem_q [2][8];
  logic wr_active_q, wr_ap_q;
  logic [3:0] wr_cnt_q, wr_len_q;
  logic [1:0] wr_bank_q;
  logic [2:0] wr_col_q;
  logic rd_active_q, rd_ap_q;
  logic [3:0] rd_cnt_q, rd_len_q, rd_wait_q;
  logic [1:0] rd_bank_q;
  logic [2:0] rd_col_q;
  logic [31:0] reg_rdata_q;

  // ========================================================================
  // Command qualification and decode
  wire cmd_ok = lnk.rise && lnk.cke_prev && ctrl_en_q && pwr_q == PWR_ACTIVE;
  wire cmd_act = cmd_ok && lnk.cmd == CMD_ACT;
  wire cmd_rd = cmd_ok && lnk.cmd == CMD_READ;
  wire cmd_wr = cmd_ok && lnk.cmd == CMD_WRITE;
  wire cmd_bst = cmd_ok && lnk.cmd == CMD_BST;
  wire cmd_pre = cmd_ok && lnk.cmd == CMD_PRE;
  wire cmd_mrs = cmd_ok && lnk.cmd == CMD_MRS;
  wire cmd_ref = cmd_ok && lnk.cke && lnk.cmd == CMD_REF;
  wire cmd_self = cmd_ok && !lnk.cke && lnk.cmd == CMD_REF;
  wire pd_enter = cmd_ok && !lnk.cke && lnk.cmd != CMD_REF;
  wire a10 = lnk.addr[`DDRCT_AP_BIT];
  wire half = lnk.rise || lnk.fall;
  wire [2:0] bl_code = mode_q[`DDRCT_BL_MSB:`DDRCT_BL_LSB];
  wire [2:0] cl_code = mode_q[`DDRCT_CL_MSB:`DDRCT_CL_LSB];
  wire [3:0] bl_len = bl_code == `DDRCT_BL8 ? `DDRCT_LEN8 :
    bl_code == `DDRCT_BL4 ? `DDRCT_LEN4 : `DDRCT_LEN2;
  wire [3:0] cl_half = cl_code == `DDRCT_CL3 ? `DDRCT_HT3 :
    cl_code == `DDRCT_CL25 ? `DDRCT_HT25 : `DDRCT_HT2;
  // While refreshing the data pins are not looked at at all.
  wire quiet = rfc_q != '0 || pwr_q == PWR_SELF || cmd_ref || cmd_self;

  // A precharge aimed at the bank being written (or at all) stops strobe use.
  wire pre_hits_wr = cmd_pre && (a10 || lnk.ba == wr_bank_q);
  wire wr_stop = cmd_rd || pre_hits_wr || quiet;
  wire wr_take = wr_active_q && lnk.dqs_edge && !wr_stop && !cmd_wr;
  wire wr_last = wr_take && wr_cnt_q == wr_len_q - 4'(1);
  wire [2:0] wr_idx = wr_col_q + wr_cnt_q[2:0];
  wire rd_kill = cmd_rd || cmd_bst || cmd_wr || quiet;
  wire rd_tick = rd_active_q && half && !rd_kill;
  wire rd_end = rd_tick && rd_wait_q == `DDRCT_WAIT_DATA
    && rd_cnt_q == rd_len_q;
  wire [2:0] rd_idx = rd_col_q + rd_cnt_q[2:0];

  // ========================================================================
  // Bank rows, one entry per bank
  for (genvar gb = 0; gb < 4; gb++) begin : g_bank
    wire hit = lnk.ba == 2'(gb);
    wire close_ap = (wr_last && wr_ap_q && wr_bank_q == 2'(gb))
      || (rd_end && rd_ap_q && rd_bank_q == 2'(gb));
    wire clr = (cmd_pre && (a10 || hit)) || close_ap;
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        bank_q[gb] <= 1'b0;
      end else if (clk_en) begin
        if (cmd_act && hit) begin
          bank_q[gb] <= 1'b1;
        end else if (clr) begin
          bank_q[gb] <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Byte-lane storage; each mask bit guards its own lane
  for (genvar gl = 0; gl < 2; gl++) begin : g_lane
    always_ff @(posedge ref_clk) begin
      if (clk_en && wr_take && !lnk.dm[gl]) begin
        mem_q[gl][wr_idx] <= lnk.dq[gl*8 +: 8];
      end
    end
  end

  // ========================================================================
  // Mode, power and refresh
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `DDRCT_MODE_RST;
      dll_off_q <= 1'b0;
      pwr_q <= PWR_ACTIVE;
      rfc_q <= '0;
    end else if (clk_en) begin
      if (cmd_mrs && lnk.ba == `DDRCT_BA_MODE) begin
        mode_q <= lnk.addr[`DDRCT_MODE_MSB:0];
      end
      if (cmd_mrs && lnk.ba == `DDRCT_BA_EXT) begin
        dll_off_q <= lnk.addr[`DDRCT_DLL_OFF_BIT];
      end
      if (cmd_ref) begin
        rfc_q <= `DDRCT_RFC_CYC;
      end else if (lnk.rise && rfc_q != '0) begin
        rfc_q <= rfc_q - 4'(1);
      end
      case (pwr_q)
        PWR_ACTIVE: begin
          if (cmd_self) begin
            pwr_q <= PWR_SELF;
          end else if (pd_enter) begin
            if (lnk.cmd == CMD_ACT || (bank_q != '0 &&
                !(lnk.cmd == CMD_PRE && a10))) begin
              pwr_q <= PWR_PD_ACT;
            end else begin
              pwr_q <= PWR_PD_PRE;
            end
          end
        end
        default: begin
          if (lnk.rise && lnk.cke) begin
            pwr_q <= PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Write burst; a new write restarts the count, so the old one is cut
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_active_q <= 1'b0;
      wr_ap_q <= 1'b0;
      wr_cnt_q <= '0;
      wr_len_q <= '0;
      wr_bank_q <= '0;
      wr_col_q <= '0;
    end else if (clk_en) begin
      if (cmd_wr) begin
        wr_active_q <= 1'b1;
        wr_ap_q <= a10;
        wr_cnt_q <= '0;
        wr_len_q <= bl_len;
        wr_bank_q <= lnk.ba;
        wr_col_q <= lnk.addr[2:0];
      end else if (wr_stop) begin
        wr_active_q <= 1'b0;
      end else if (wr_take) begin
        wr_cnt_q <= wr_cnt_q + 4'(1);
        wr_active_q <= !wr_last;
      end
    end
  end

  // ========================================================================
  // Read burst, paced in half link cycles so that a latency of 2.5 works
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_active_q <= 1'b0;
      rd_ap_q <= 1'b0;
      rd_cnt_q <= '0;
      rd_len_q <= '0;
      rd_wait_q <= '0;
      rd_bank_q <= '0;
      rd_col_q <= '0;
      dq_o <= '0;
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe <= 1'b0;
    end else if (clk_en) begin
      if (cmd_rd && !quiet) begin
        rd_active_q <= 1'b1;
        rd_ap_q <= a10;
        rd_cnt_q <= '0;
        rd_len_q <= bl_len;
        rd_wait_q <= cl_half;
        rd_bank_q <= lnk.ba;
        rd_col_q <= lnk.addr[2:0];
      end else if (rd_kill || rd_end) begin
        rd_active_q <= 1'b0;
        dq_oe <= 1'b0;
        dqs_oe <= 1'b0;
      end else if (rd_tick) begin
        if (rd_wait_q != `DDRCT_WAIT_DATA) begin
          rd_wait_q <= rd_wait_q - 4'(1);
          if (rd_wait_q == `DDRCT_WAIT_PRE) begin
            dqs_oe <= 1'b1;
            dqs_o <= 1'b0;
          end
        end else begin
          dq_o <= {mem_q[1][rd_idx], mem_q[0][rd_idx]};
          dq_oe <= 1'b1;
          dqs_o <= !rd_cnt_q[0];
          rd_cnt_q <= rd_cnt_q + 4'(1);
        end
      end
    end
  end

  // ========================================================================
  // Register port; unmapped addresses read as zero
  wire [31:0] status_w = {21'h0, !dll_off_q, rd_active_q, wr_active_q,
    rfc_q != '0, pwr_q == PWR_SELF, pwr_q == PWR_PD_ACT,
    pwr_q == PWR_PD_PRE, bank_q};
  wire [31:0] rd_mux = reg_addr == `DDRCT_REG_CTRL ? {31'h0, ctrl_en_q} :
    reg_addr == `DDRCT_REG_STATUS ? status_w :
    reg_addr == `DDRCT_REG_MODE ? {25'h0, mode_q} :
    reg_addr == `DDRCT_REG_WCOUNT ? wcount_q : 32'h0;
  wire ctrl_wr = reg_wr && reg_addr == `DDRCT_REG_CTRL;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_en_q <= `DDRCT_CTRL_EN_RST;
      wcount_q <= '0;
      reg_rdata_q <= '0;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        ctrl_en_q <= reg_wdata[`DDRCT_CTRL_EN];
      end
      // An element taken in the clearing cycle is still counted.
      if (wr_take) begin
        wcount_q <= (ctrl_wr && reg_wdata[`DDRCT_CTRL_CLR]) ? 32'h1 :
          wcount_q + 32'h1;
      end else if (ctrl_wr && reg_wdata[`DDRCT_CTRL_CLR]) begin
        wcount_q <= '0;
      end
      reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = reg_rdata_q;
endmodule : ddrct_core

// ===== sim/ddrct_core_assertions.sv
`timescale 1ns/1ps
`include "ddrct_defines.svh"
// ==========================================================================
// Port checks on the read strobe path and the register port.
module ddrct_core_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Read path
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  // Register port
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic st_rd;
  assign st_rd = reg_rd && reg_addr == `DDRCT_REG_STATUS;

  a_rdata_zero_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_data_in_strobe:
    assert property (dq_oe |-> dqs_oe) else $error("data without strobe");
  a_preamble_low:
    assert property ($rose(dqs_oe) |-> !dqs_o && !dq_oe)
    else $error("strobe preamble not low");
  a_first_elem_high:
    assert property ($rose(dq_oe) |-> dqs_o && $past(dqs_oe))
    else $error("first element without preamble");
  a_burst_bounded:
    assert property ($rose(dq_oe) |-> ##[1:160] !dq_oe)
    else $error("read burst does not end");
  a_elem_hold:
    assert property (dq_oe && $changed(dqs_o) |=>
      (!dq_oe || $stable(dqs_o)) [*2]) else $error("element too short");
  a_data_hold:
    assert property (dq_oe && $past(dq_oe) && $stable(dqs_o) |->
      $stable(dq_o)) else $error("data moved inside an element");
  a_refresh_quiet:
    assert property ($past(st_rd) && reg_rdata[`DDRCT_ST_RFC] |->
      !dq_oe && !dqs_oe) else $error("outputs driven in refresh");
  a_pd_one_kind:
    assert property ($past(st_rd) |->
      !(reg_rdata[`DDRCT_ST_PD_PRE] && reg_rdata[`DDRCT_ST_PD_ACT]))
    else $error("both power-down kinds");
  c_read: cover property ($rose(dq_oe));
  c_pd_act: cover property ($past(st_rd) && reg_rdata[`DDRCT_ST_PD_ACT]);
  c_self: cover property ($past(st_rd) && reg_rdata[`DDRCT_ST_SELF]);
endmodule : ddrct_core_assertions

bind ddrct_core ddrct_core_assertions i_ddrct_core_assertions (.ref_clk,
  .resetn, .dq_o, .dq_oe, .dqs_o, .dqs_oe, .reg_rd, .reg_addr, .reg_rdata);

// ===== sim/ddrct_ctrl_model.sv
`timescale 1ns/1ps
`include "ddrct_defines.svh"
// ==========================================================================
// Memory controller model: free-running link clock, commands, write data.
module ddrct_ctrl_model (
  // Link clock and enable
  output logic mem_clk,
  output logic mem_cke,
  // Command and address
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [12:0] addr,
  output logic [1:0] ba,
  // Write data
  output logic [15:0] dq_i,
  output logic dqs_i,
  output logic upper_byte_mask,
  output logic lower_byte_mask
);
  initial begin
    {mem_cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
    addr = 13'h0;
    ba = 2'h0;
    dq_i = 16'h0;
    dqs_i = 1'b0;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
    mem_clk = 1'b0;
    #13;
    forever #200 mem_clk = ~mem_clk;
  end

  // Pins change on the falling link edge so the rise sees them settled.
  task automatic issue(input logic [3:0] pat, input logic [1:0] b,
      input logic [12:0] a, input logic cke);
    @(negedge mem_clk);
    {cs_n, ras_n, cas_n, we_n} = pat;
    ba = b;
    addr = a;
    mem_cke = cke;
    @(negedge mem_clk);
    {cs_n, ras_n, cas_n, we_n} = `DDRCT_PAT_NOP;
    ba = ~b;
    addr = ~a;
  endtask : issue

  // Each strobe edge carries one element; data is inverted once released.
  task automatic write_data(input int n, input logic [15:0] base,
      input logic [1:0] mask);
    {upper_byte_mask, lower_byte_mask} = mask;
    for (int k = 0; k < n; k++) begin
      dq_i = base + 16'(k) * 16'h0101;
      #100 dqs_i = ~dqs_i;
      #100;
    end
    dq_i = ~dq_i;
    {upper_byte_mask, lower_byte_mask} = ~mask;
  endtask : write_data
endmodule : ddrct_ctrl_model

// ===== sim/ddrct_core_tb.sv
`timescale 1ns/1ps
`include "ddrct_defines.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  error_cnt++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module ddrct_core_tb;
  logic ref_clk, resetn, clk_en, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  wire logic [31:0] reg_rdata;
  wire logic mem_clk, mem_cke, cs_n, ras_n, cas_n, we_n, dqs_i, dqs_o;
  wire logic upper_byte_mask, lower_byte_mask, dq_oe, dqs_oe;
  wire logic [12:0] addr;
  wire logic [1:0] ba;
  wire logic [15:0] dq_i, dq_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [15:0] rd_q[$];
  logic dqs_prev = 1'b0;

  ddrct_ctrl_model i_ddrct_ctrl_model (.mem_clk, .mem_cke, .cs_n, .ras_n,
    .cas_n, .we_n, .addr, .ba, .dq_i, .dqs_i, .upper_byte_mask,
    .lower_byte_mask);
  ddrct_core i_ddrct_core (.ref_clk, .resetn, .clk_en, .mem_clk, .mem_cke,
    .cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .upper_byte_mask,
    .lower_byte_mask, .dq_i, .dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Read elements are taken on each strobe change while data is driven.
  always @(posedge ref_clk) begin
    if (dq_oe === 1'b1 && dqs_o !== dqs_prev)
      rd_q.push_back(dq_o);
    dqs_prev <= dqs_o;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input string nm, input logic [3:0] a,
      input logic [31:0] msk, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(nm, exp, reg_rdata & msk)
  endtask : reg_check

  task automatic idle(input int n);
    repeat (n) @(posedge mem_clk);
  endtask : idle

  task automatic cmd(input logic [3:0] p, input logic [1:0] b,
      input logic [12:0] a);
    i_ddrct_ctrl_model.issue(p, b, a, 1'b1);
  endtask : cmd

  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    clk_en = 1'b1;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    reg_check("ctrl", `DDRCT_REG_CTRL, '1, 32'h1);
    reg_check("mode", `DDRCT_REG_MODE, 32'h7f, 32'h22);
    reg_check("status", `DDRCT_REG_STATUS, 32'h3ff, 32'h0);
    reg_check("unmapped", 4'h2, '1, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    reg_check("frozen", `DDRCT_REG_CTRL, '1, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    $display("reset test done");
    cmd(`DDRCT_PAT_PRE, 2'h0, 13'h400);
    cmd(`DDRCT_PAT_MRS, `DDRCT_BA_EXT, 13'h0);
    idle(2);
    cmd(`DDRCT_PAT_MRS, `DDRCT_BA_MODE, 13'h122);
    idle(200);
    cmd(`DDRCT_PAT_PRE, 2'h0, 13'h400);
    cmd(`DDRCT_PAT_REF, 2'h0, 13'h0);
    reg_check("busy", `DDRCT_REG_STATUS, 32'h80, 32'h80);
    idle(4);
    cmd(`DDRCT_PAT_REF, 2'h0, 13'h0);
    idle(4);
    cmd(`DDRCT_PAT_MRS, `DDRCT_BA_MODE, 13'h022);
    idle(2);
    reg_check("idle", `DDRCT_REG_STATUS, 32'h3ff, 32'h0);
    reg_write(`DDRCT_REG_CTRL, 32'h0);
    cmd(`DDRCT_PAT_ACT, 2'h0, 13'h0);
    idle(2);
    reg_check("off", `DDRCT_REG_STATUS, 32'hf, 32'h0);
    reg_write(`DDRCT_REG_CTRL, 32'h1);
    $display("init test done");
    cmd(`DDRCT_PAT_ACT, 2'h0, 13'h0);
    idle(2);
    reg_check("open", `DDRCT_REG_STATUS, 32'hf, 32'h1);
    cmd(`DDRCT_PAT_WRITE, 2'h0, 13'h0);
    i_ddrct_ctrl_model.write_data(4, 16'ha000, 2'h0);
    idle(2);
    cmd(`DDRCT_PAT_WRITE, 2'h0, 13'h0);
    i_ddrct_ctrl_model.write_data(4, 16'h5055, 2'h2);
    idle(2);
    reg_check("wcount", `DDRCT_REG_WCOUNT, '1, 32'h8);
    reg_check("kept", `DDRCT_REG_STATUS, 32'hf, 32'h1);
    rd_q.delete();
    cmd(`DDRCT_PAT_READ, 2'h0, 13'h0);
    idle(8);
    `CHK("count", 4, rd_q.size())
    for (int k = 0; k < 4; k++)
      `CHK("data", 16'ha055 + 16'(k) * 16'h0101, rd_q[k])
    $display("write read test done");
    reg_write(`DDRCT_REG_CTRL, 32'h3);
    cmd(`DDRCT_PAT_BST, 2'h0, 13'h0);
    cmd(`DDRCT_PAT_WRITE, 2'h0, 13'h4);
    fork
      i_ddrct_ctrl_model.write_data(4, 16'hb000, 2'h0);
    join_none
    cmd(`DDRCT_PAT_PRE, 2'h0, 13'h0);
    idle(3);
    reg_check("cut", `DDRCT_REG_WCOUNT, '1, 32'h3);
    reg_check("closed", `DDRCT_REG_STATUS, 32'hf, 32'h0);
    cmd(`DDRCT_PAT_MRS, `DDRCT_BA_MODE, 13'h023);
    idle(2);
    reg_check("bl8", `DDRCT_REG_MODE, 32'h7f, 32'h23);
    cmd(`DDRCT_PAT_ACT, 2'h1, 13'h0);
    cmd(`DDRCT_PAT_ACT, 2'h2, 13'h0);
    reg_write(`DDRCT_REG_CTRL, 32'h3);
    cmd(`DDRCT_PAT_WRITE, 2'h2, 13'h0);
    fork
      i_ddrct_ctrl_model.write_data(4, 16'hc000, 2'h0);
    join_none
    cmd(`DDRCT_PAT_WRITE, 2'h1, 13'h0);
    rd_q.delete();
    cmd(`DDRCT_PAT_READ, 2'h1, 13'h0);
    idle(10);
    reg_check("split", `DDRCT_REG_WCOUNT, '1, 32'h4);
    `CHK("new", 16'hc303, rd_q[0])
    `CHK("old1", 16'hc101, rd_q[1])
    `CHK("old2", 16'hc202, rd_q[2])
    $display("interrupt test done");
    cmd(`DDRCT_PAT_PRE, 2'h3, 13'h400);
    idle(2);
    reg_check("all", `DDRCT_REG_STATUS, 32'hf, 32'h0);
    i_ddrct_ctrl_model.issue(`DDRCT_PAT_NOP, 2'h0, 13'h0, 1'b0);
    idle(2);
    reg_check("pd_pre", `DDRCT_REG_STATUS, 32'h30, 32'h10);
    cmd(`DDRCT_PAT_NOP, 2'h0, 13'h0);
    cmd(`DDRCT_PAT_ACT, 2'h3, 13'h0);
    i_ddrct_ctrl_model.issue(`DDRCT_PAT_NOP, 2'h0, 13'h0, 1'b0);
    idle(2);
    reg_check("pd_act", `DDRCT_REG_STATUS, 32'h30, 32'h20);
    cmd(`DDRCT_PAT_NOP, 2'h0, 13'h0);
    cmd(`DDRCT_PAT_WRITE, 2'h3, 13'h400);
    i_ddrct_ctrl_model.write_data(8, 16'hd000, 2'h0);
    idle(3);
    reg_check("auto", `DDRCT_REG_STATUS, 32'hf, 32'h0);
    i_ddrct_ctrl_model.issue(`DDRCT_PAT_REF, 2'h0, 13'h0, 1'b0);
    idle(2);
    reg_check("self", `DDRCT_REG_STATUS, 32'h70, 32'h40);
    cmd(`DDRCT_PAT_NOP, 2'h0, 13'h0);
    idle(200);
    reg_check("awake", `DDRCT_REG_STATUS, 32'h7ff, 32'h400);
    $display("power test done");
    report_and_stop();
  end
endmodule : ddrct_core_tb
